// file: smrc_pkg.sv
/*
  smrc_pkg: constants and types for the supply mode and reset controller.
  assumes a 100 MHz device clock; supply levels arrive as digital comparator flags.
*/
package smrc_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ                   = 100;
  localparam int unsigned LIMP_HOME_ACK_TIME_US     = 40;   // longest acknowledgement time
  localparam int unsigned LIMP_HOME_ACK_CYCLES      = LIMP_HOME_ACK_TIME_US * CLK_MHZ;
  localparam int unsigned UV_RECOVERY_MIN_US        = 2500; // recovery delay, least
  localparam int unsigned UV_RECOVERY_MAX_US        = 5500; // recovery delay, most
  localparam int unsigned UV_RECOVERY_CYCLES        = UV_RECOVERY_MIN_US * CLK_MHZ;
  localparam int unsigned STANDBY_TRANSITION_US     = 30;
  localparam int unsigned STANDBY_TRANSITION_CYCLES = STANDBY_TRANSITION_US * CLK_MHZ;
  localparam int unsigned POWER_ON_WAKEUP_US        = 30;
  localparam int unsigned POWER_ON_WAKEUP_CYCLES    = POWER_ON_WAKEUP_US * CLK_MHZ;

  // field values
  localparam logic [2:0] MUX_SLEEP_CODE   = 3'h7;
  localparam logic [2:0] MUX_RESET_VALUE  = 3'h7;
  localparam logic       COLLECT_RESET    = 1'h0;

  // operation modes, gray along power-up, sleep, stand-by, active
  typedef enum logic [2:0] {
    SMRC_UNSUPPLIED = 3'h0,
    SMRC_POWER_UP   = 3'h1,
    SMRC_SLEEP      = 3'h3,
    SMRC_STANDBY    = 3'h2,
    SMRC_ACTIVE     = 3'h6,
    SMRC_READY      = 3'h7,
    SMRC_LIMP       = 3'h5,
    SMRC_LIMP_ACT   = 3'h4
  } smrc_mode_type;

  // supply monitor levels, asynchronous, synchronised in smrc_ctrl
  typedef struct packed {
    logic logic_supply_ok;   // digital supply above power-on threshold
    logic battery_above_tp;  // above battery transient level
    logic battery_above_uv;  // above undervoltage shutdown threshold
    logic battery_above_op;  // above minimum operating threshold
  } smrc_supply_type;

  // standard diagnosis flags
  typedef struct packed {
    logic limp_home_flag;
    logic supply_monitor_flag;
    logic transmission_error_flag;
  } smrc_diag_type;

endpackage : smrc_pkg

// file: smrc_sync.sv
/*
  smrc_sync: two-flop synchronisers, one per bit.
  assumes inputs are asynchronous levels from pins or analog comparators.
*/
`timescale 1ns/100ps
module smrc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : smrc_sync

// file: smrc_timer.sv
/*
  smrc_timer: counts cycles while its condition holds, flags done at the limit.
  assumes a single clock; clearing the condition restarts the count.
*/
`timescale 1ns/100ps
module smrc_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int          CW    = $clog2(LIMIT + 1)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic run,
  output logic      done
);

  logic [CW-1:0] count_reg;
  wire           at_limit = (count_reg == CW'(LIMIT));

  // saturating count while run holds
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      count_reg <= '0;
    end else if (!at_limit) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign done = at_limit && run;

endmodule : smrc_timer

// file: smrc_ctrl.sv
/*
  smrc_ctrl: operation mode, register reset and diagnosis flag control
  for a multi-channel high-side switch.
  assumes register storage and the serial frame logic sit outside; supply
  comparators and the input pins are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
module smrc_ctrl
  import smrc_pkg::*;
#(
  parameter int          CHANNELS    = 4,
  parameter int unsigned ACK_CYCLES  = smrc_pkg::LIMP_HOME_ACK_CYCLES,
  parameter int unsigned UV_CYCLES   = smrc_pkg::UV_RECOVERY_CYCLES,
  parameter int unsigned STBY_CYCLES = smrc_pkg::STANDBY_TRANSITION_CYCLES,
  parameter int unsigned WU_CYCLES   = smrc_pkg::POWER_ON_WAKEUP_CYCLES
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // pins and supply comparators, asynchronous
  input  wire logic [CHANNELS-1:0]     channel_input_pins,
  input  wire logic                    limp_home_input,
  input  wire smrc_pkg::smrc_supply_type supply_in,
  // register fields from the serial block
  input  wire logic [2:0]              sense_mux_select,
  input  wire logic                    input_collect_enable,
  input  wire logic [CHANNELS-1:0]     channel_on_bits,
  input  wire logic                    config_reset_command,
  input  wire logic                    diag_transmitted,
  // mode and outputs
  output smrc_pkg::smrc_mode_type      mode,
  output logic [CHANNELS-1:0]          channel_drive,
  output logic                         protection_enable,
  output logic                         battery_monitor_enable,
  output logic                         register_write_enable,
  output logic                         serial_ready,
  output logic                         sense_available,
  // resets to register file and counters
  output logic                         config_reset,
  output logic                         error_warning_reset,
  output logic                         restart_counter_reset,
  output logic                         diag_word_reset,
  // diagnosis
  output smrc_pkg::smrc_diag_type      standard_diag_word,
  output logic                         monitor_flag_valid
);

  // synchronised levels
  logic [CHANNELS-1:0] pins_s;
  logic                limp_s;
  smrc_supply_type     sup_s;

  smrc_sync #(.WIDTH(CHANNELS + 5)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({channel_input_pins, limp_home_input, supply_in}),
    .sync_out ({pins_s, limp_s, sup_s})
  );

  // limp acknowledgement and undervoltage recovery timers
  logic limp_ack;
  logic uv_done;
  logic stby_done;
  logic wu_done;
  logic uv_lock_reg;

  smrc_timer #(.LIMIT(ACK_CYCLES)) u_ack (
    .clk  (clk),
    .srst (srst),
    .run  (limp_s && sup_s.battery_above_tp),
    .done (limp_ack)
  );

  smrc_timer #(.LIMIT(UV_CYCLES)) u_uv (
    .clk  (clk),
    .srst (srst),
    .run  (uv_lock_reg && sup_s.battery_above_op),
    .done (uv_done)
  );

  // decoding of the mode inputs
  wire mux_sleep   = (sense_mux_select == MUX_SLEEP_CODE);
  wire pins_any    = |pins_s;
  wire pin_cmd     = input_collect_enable && pins_any;
  wire switch_cmd  = pin_cmd || (|channel_on_bits);
  wire all_low     = !pins_any && !limp_s;
  wire logic_ok    = sup_s.logic_supply_ok;
  wire cfg_rst_ok  = config_reset_command && sup_s.battery_above_tp;
  wire limp_tp_hit = limp_s && !sup_s.battery_above_tp;

  smrc_mode_type mode_reg;
  smrc_mode_type mode_next;

  // mode transitions
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      SMRC_UNSUPPLIED: begin
        if (logic_ok || sup_s.battery_above_op) mode_next = SMRC_POWER_UP;
      end
      SMRC_POWER_UP: begin
        if (logic_ok && sup_s.battery_above_op && wu_done) mode_next = SMRC_SLEEP;
      end
      SMRC_SLEEP, SMRC_STANDBY, SMRC_READY, SMRC_ACTIVE: begin
        // logic supply loss with all pins low holds sleep, since the register fields sit in reset
        if (limp_ack) mode_next = SMRC_LIMP;
        else if (!logic_ok && !pins_any)
          mode_next = SMRC_SLEEP;
        else if (mux_sleep && switch_cmd) mode_next = SMRC_READY;
        else if (all_low && mux_sleep) mode_next = SMRC_SLEEP;
        else if (!mux_sleep && switch_cmd) mode_next = SMRC_ACTIVE;
        else if (!mux_sleep) mode_next = SMRC_STANDBY;
      end
      SMRC_LIMP: begin
        if (!limp_s) mode_next = SMRC_SLEEP;
        else if (pins_any) mode_next = SMRC_LIMP_ACT;
      end
      SMRC_LIMP_ACT: begin
        if (!limp_s) mode_next = SMRC_SLEEP;
        else if (!pins_any) mode_next = SMRC_LIMP;
      end
      default: mode_next = SMRC_UNSUPPLIED;
    endcase
    if (!logic_ok && !sup_s.battery_above_op && !sup_s.battery_above_tp && mode_reg != SMRC_UNSUPPLIED)
      mode_next = SMRC_UNSUPPLIED;
  end

  // single state register on the device clock
  always_ff @(posedge clk) begin
    if (srst) mode_reg <= SMRC_UNSUPPLIED;
    else      mode_reg <= mode_next;
  end

  // wake-up and stand-by timers hinge on the mode
  smrc_timer #(.LIMIT(WU_CYCLES)) u_wu (
    .clk  (clk),
    .srst (srst),
    .run  (mode_reg == SMRC_POWER_UP && logic_ok && sup_s.battery_above_op),
    .done (wu_done)
  );

  smrc_timer #(.LIMIT(STBY_CYCLES)) u_stby (
    .clk  (clk),
    .srst (srst),
    .run  (mode_reg != SMRC_SLEEP && mode_reg != SMRC_UNSUPPLIED),
    .done (stby_done)
  );

  // undervoltage lock: set below shutdown in active or limp active mode, freed after recovery
  wire op_mode   = (mode_reg == SMRC_ACTIVE) || (mode_reg == SMRC_LIMP_ACT);
  wire uv_event  = !sup_s.battery_above_uv;
  wire mon_mode  = (mode_reg == SMRC_STANDBY) || (mode_reg == SMRC_ACTIVE) || (mode_reg == SMRC_LIMP);

  always_ff @(posedge clk) begin
    if (srst) uv_lock_reg <= 1'h0;
    else if (op_mode && uv_event) uv_lock_reg <= 1'h1;
    else if (uv_done) uv_lock_reg <= 1'h0;
  end

  // reset conditions
  logic logic_ok_d_reg;
  wire  limp_reset  = limp_ack;                                         // level while acknowledged
  wire  logic_reset = !logic_ok;
  wire  any_reset   = limp_reset || logic_reset || cfg_rst_ok;

  always_ff @(posedge clk) begin
    if (srst) begin
      logic_ok_d_reg <= 1'h0;
    end else begin
      logic_ok_d_reg <= logic_ok;
    end
  end

  // channel drive selection
  wire          limp_modes = (mode_reg == SMRC_LIMP) || (mode_reg == SMRC_LIMP_ACT);
  logic [CHANNELS-1:0] drive_next;
  always_comb begin
    drive_next = '0;
    if (mode_reg == SMRC_ACTIVE && !mux_sleep)
      drive_next = channel_on_bits | (input_collect_enable ? pins_s : '0);
    else if (mode_reg == SMRC_LIMP_ACT)
      drive_next = pins_s;
    if (uv_lock_reg || (op_mode && uv_event)) drive_next = '0;
    if (any_reset && !pins_any) drive_next = '0;
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      mode                   <= SMRC_UNSUPPLIED;
      channel_drive          <= '0;
      protection_enable      <= 1'h0;
      battery_monitor_enable <= 1'h0;
      register_write_enable  <= 1'h0;
      serial_ready           <= 1'h0;
      sense_available        <= 1'h0;
      config_reset           <= 1'h1;
      error_warning_reset    <= 1'h1;
      restart_counter_reset  <= 1'h1;
      diag_word_reset        <= 1'h1;
      monitor_flag_valid     <= 1'h0;
    end else begin
      mode                   <= mode_reg;
      channel_drive          <= drive_next;
      protection_enable      <= mode_reg != SMRC_SLEEP && mode_reg != SMRC_UNSUPPLIED;
      battery_monitor_enable <= mode_reg != SMRC_SLEEP && mode_reg != SMRC_UNSUPPLIED;
      register_write_enable  <= logic_ok && !limp_modes
                                && mode_reg != SMRC_UNSUPPLIED && mode_reg != SMRC_POWER_UP
                                && (mode_reg == SMRC_SLEEP || sup_s.battery_above_tp);
      serial_ready           <= logic_ok && mode_reg != SMRC_UNSUPPLIED && mode_reg != SMRC_POWER_UP;
      sense_available        <= !limp_modes && !mux_sleep;
      config_reset           <= any_reset;
      error_warning_reset    <= limp_reset || logic_reset;
      restart_counter_reset  <= limp_reset
                                || (logic_reset && !sup_s.battery_above_tp && !limp_s);
      diag_word_reset        <= logic_reset;
      monitor_flag_valid     <= stby_done;
    end
  end

  // diagnosis flags: a set in the clearing cycle wins
  smrc_diag_type diag_next;
  always_comb begin
    diag_next = standard_diag_word;
    if (diag_transmitted) diag_next = '0;
    if (limp_s) diag_next.limp_home_flag = 1'h1;
    if (mon_mode && uv_event) diag_next.supply_monitor_flag = 1'h1;
    if (limp_tp_hit) begin
      diag_next.limp_home_flag          = 1'h1;
      diag_next.supply_monitor_flag     = 1'h1;
      diag_next.transmission_error_flag = 1'h1;
    end
    if (!logic_ok_d_reg && logic_ok) diag_next.transmission_error_flag = 1'h1;
  end

  always_ff @(posedge clk) begin
    if (srst) standard_diag_word <= '0;
    else      standard_diag_word <= diag_next;
  end

endmodule : smrc_ctrl

// file: smrc_ctrl_assertions.sv
/*
  smrc_ctrl_assertions: port-level checks of the mode and reset controller.
  assumes the design's reset and clock; bound to every smrc_ctrl instance.
*/
`timescale 1ns/100ps
module smrc_ctrl_assertions
  import smrc_pkg::*;
#(
  parameter int          CHANNELS   = 4,
  parameter int unsigned ACK_CYCLES = 16
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     srst,
  // inputs watched
  input wire logic [CHANNELS-1:0]      channel_input_pins,
  input wire logic                     limp_home_input,
  input wire smrc_pkg::smrc_supply_type supply_in,
  input wire logic [2:0]               sense_mux_select,
  input wire logic                     diag_transmitted,
  // outputs watched
  input wire smrc_pkg::smrc_mode_type  mode,
  input wire logic [CHANNELS-1:0]      channel_drive,
  input wire logic                     protection_enable,
  input wire logic                     battery_monitor_enable,
  input wire logic                     register_write_enable,
  input wire logic                     serial_ready,
  input wire logic                     sense_available,
  input wire smrc_pkg::smrc_diag_type  standard_diag_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // unbroken high time of the limp input
  logic [31:0] lh_cnt_reg;
  always_ff @(posedge clk) begin
    if (srst || !limp_home_input) begin
      lh_cnt_reg <= '0;
    end else if (lh_cnt_reg != 32'hffffffff) begin
      lh_cnt_reg <= lh_cnt_reg + 32'h1;
    end
  end
  // limp input rises and stays with no diagnosis read
  sequence limp_held_s;
    $rose(limp_home_input) ##1 (limp_home_input && supply_in.logic_supply_ok && !diag_transmitted)[*5];
  endsequence
  // driving channels, battery dips six cycles and comes back; needs a recovery count above 8
  sequence uv_bounce_s;
    (channel_drive != '0 && $fell(supply_in.battery_above_uv)) ##1 (!supply_in.battery_above_uv)[*5]
      ##1 (supply_in.battery_above_uv && supply_in.battery_above_op)[*8];
  endsequence
  a_sleep_outputs_off: assert property (
    (mode == SMRC_SLEEP)[*2] |-> channel_drive == '0 && !protection_enable && !battery_monitor_enable)
    else $error("sleep with outputs or protection on");
  a_sleep_writable: assert property (
    (mode == SMRC_SLEEP && supply_in.logic_supply_ok)[*4] |-> register_write_enable)
    else $error("sleep refuses register writes");
  a_standby_serial_ok: assert property (
    (mode == SMRC_STANDBY)[*2] |-> channel_drive == '0 && serial_ready)
    else $error("stand-by outputs wrong");
  a_ready_outputs_off: assert property (
    (mode == SMRC_READY)[*2] |-> channel_drive == '0)
    else $error("ready mode drives a channel");
  a_mux_blocks_active: assert property (
    (sense_mux_select == MUX_SLEEP_CODE)[*6] |-> mode != SMRC_ACTIVE)
    else $error("active mode with sleep code");
  a_limp_after_ack: assert property (
    $rose(mode == SMRC_LIMP) |-> lh_cnt_reg >= ACK_CYCLES && !register_write_enable)
    else $error("limp mode entered early or writable");
  a_limp_flag_set: assert property (
    limp_held_s |-> standard_diag_word.limp_home_flag)
    else $error("limp flag not set");
  a_limp_act_protect: assert property (
    (mode == SMRC_LIMP_ACT)[*2] |-> protection_enable && !sense_available)
    else $error("limp active protection wrong");
  a_uv_outputs_off: assert property (
    (!supply_in.battery_above_uv)[*6] |-> channel_drive == '0)
    else $error("channel on under battery undervoltage");
  a_uv_restart_delay: assert property (
    uv_bounce_s |-> channel_drive == '0)
    else $error("restart before recovery delay");
endmodule : smrc_ctrl_assertions
bind smrc_ctrl smrc_ctrl_assertions #(.CHANNELS(CHANNELS), .ACK_CYCLES(ACK_CYCLES)) i_smrc_ctrl_assertions (
  .clk, .srst, .channel_input_pins, .limp_home_input, .supply_in, .sense_mux_select, .diag_transmitted,
  .mode, .channel_drive, .protection_enable, .battery_monitor_enable, .register_write_enable,
  .serial_ready, .sense_available, .standard_diag_word);

// file: smrc_host.sv
/*
  smrc_host: host model driving the pins and register fields of the controller.
  assumes the bench calls its tasks; fields change on the falling clock edge.
*/
`timescale 1ns/100ps
module smrc_host #(
  parameter int WU = 10
) (
  // clock and device view
  input  wire logic                     clk,
  input  wire smrc_pkg::smrc_supply_type supply_in,
  input  wire logic                     monitor_flag_valid,
  input  wire smrc_pkg::smrc_diag_type  standard_diag_word,
  // pins and register fields
  output logic [3:0]                    channel_input_pins,
  output logic                          limp_home_input,
  output logic [2:0]                    sense_mux_select,
  output logic                          input_collect_enable,
  output logic [3:0]                    channel_on_bits,
  output logic                          config_reset_command,
  output logic                          diag_transmitted
);
  import smrc_pkg::*;
  // reset values at time zero
  initial begin
    channel_input_pins   = '0;
    limp_home_input      = 1'h0;
    sense_mux_select     = MUX_RESET_VALUE;
    input_collect_enable = COLLECT_RESET;
    channel_on_bits      = '0;
    config_reset_command = 1'h0;
    diag_transmitted     = 1'h0;
  end
  // no field access until the wake-up time has run
  task automatic wake;
    wait (supply_in.logic_supply_ok === 1'b1);
    repeat (WU) @(negedge clk);
  endtask : wake
  // pins and fields change together
  task automatic put(input logic [2:0] m, input logic [3:0] o, input logic c, input logic [3:0] p, input logic l);
    @(negedge clk);
    sense_mux_select     <= m;
    channel_on_bits      <= o;
    input_collect_enable <= c;
    channel_input_pins   <= p;
    limp_home_input      <= l;
  endtask : put
  // configuration reset command level
  task automatic cmd(input logic v);
    @(negedge clk);
    config_reset_command <= v;
  endtask : cmd
  // fetch the diagnosis word, which clears its flags
  task automatic read(output smrc_pkg::smrc_diag_type d);
    wait (monitor_flag_valid === 1'b1);
    @(negedge clk);
    d = standard_diag_word;
    diag_transmitted <= 1'b1;
    @(negedge clk);
    diag_transmitted <= 1'b0;
  endtask : read
endmodule : smrc_host

// file: smrc_ctrl_tb.sv
/*
  smrc_ctrl_tb: self-checking bench for the supply mode and reset controller.
  assumes shortened timing counts; the host model drives pins and fields.
*/
`timescale 1ns/100ps
module smrc_ctrl_tb;
  import smrc_pkg::*;
  // shortened counts
  localparam int ACK = 12;
  localparam int UV  = 20;
  localparam int WU  = 10;
  // one ordinary case: fields, then expected mode and drive
  typedef struct packed {
    logic [2:0]    m;
    logic [3:0]    o;
    logic          c;
    logic [3:0]    p;
    smrc_mode_type md;
    logic [3:0]    d;
  } smrc_row_type;
  // design signals
  logic            clk, srst, limp_home_input, input_collect_enable, config_reset_command;
  logic            diag_transmitted, protection_enable, battery_monitor_enable, register_write_enable;
  logic            serial_ready, sense_available, config_reset, error_warning_reset;
  logic            restart_counter_reset, diag_word_reset, monitor_flag_valid;
  logic [2:0]      sense_mux_select;
  logic [3:0]      channel_input_pins, channel_on_bits, channel_drive;
  smrc_supply_type supply_in;
  smrc_mode_type   mode;
  smrc_diag_type   standard_diag_word, dw;
  int              n_fail, check_count;
  smrc_row_type    rows [8] = '{
    '{3'h7, 4'h0, 1'h0, 4'h0, SMRC_SLEEP, 4'h0},
    '{3'h0, 4'h0, 1'h0, 4'h0, SMRC_STANDBY, 4'h0},
    '{3'h0, 4'h5, 1'h0, 4'h0, SMRC_ACTIVE, 4'h5},
    '{3'h7, 4'h5, 1'h0, 4'h0, SMRC_READY, 4'h0},
    '{3'h7, 4'h0, 1'h1, 4'h2, SMRC_READY, 4'h0},
    '{3'h1, 4'h0, 1'h1, 4'h2, SMRC_ACTIVE, 4'h2},
    '{3'h1, 4'h0, 1'h0, 4'h2, SMRC_STANDBY, 4'h0},
    '{3'h7, 4'h0, 1'h0, 4'h0, SMRC_SLEEP, 4'h0}};
  // device and host
  smrc_ctrl #(.ACK_CYCLES(ACK), .UV_CYCLES(UV), .STBY_CYCLES(8), .WU_CYCLES(WU)) i_smrc_ctrl (
    .clk, .srst, .channel_input_pins, .limp_home_input, .supply_in, .sense_mux_select,
    .input_collect_enable, .channel_on_bits, .config_reset_command, .diag_transmitted, .mode,
    .channel_drive, .protection_enable, .battery_monitor_enable, .register_write_enable,
    .serial_ready, .sense_available, .config_reset, .error_warning_reset, .restart_counter_reset,
    .diag_word_reset, .standard_diag_word, .monitor_flag_valid);
  smrc_host #(.WU(WU)) i_smrc_host (
    .clk, .supply_in, .monitor_flag_valid, .standard_diag_word, .channel_input_pins, .limp_home_input,
    .sense_mux_select, .input_collect_enable, .channel_on_bits, .config_reset_command, .diag_transmitted);
  // compare and count
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // falling edges to let outputs settle
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well past the expected run
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  // main sequence
  initial begin
    srst = 1'b1;
    supply_in = 4'hf;
    wt(16);
    chk("rst mode", 8'(mode), 8'(SMRC_UNSUPPLIED));
    chk("rst drive", 8'({channel_drive, config_reset}), 8'h1);
    srst = 1'b0;
    i_smrc_host.wake();
    foreach (rows[i]) begin
      i_smrc_host.put(rows[i].m, rows[i].o, rows[i].c, rows[i].p, 1'h0);
      wt(8);
      chk("mode", 8'(mode), 8'(rows[i].md));
      chk("drive", 8'(channel_drive), 8'(rows[i].d));
    end
    // limp home entry, then a pin high
    i_smrc_host.put(3'h7, 4'h0, 1'h0, 4'h0, 1'h1);
    wt(6);
    chk("limp flag", 8'(standard_diag_word.limp_home_flag), 8'h1);
    wt(ACK + 4);
    chk("limp mode", 8'({mode, register_write_enable}), 8'({SMRC_LIMP, 1'b0}));
    chk("limp resets", 8'({config_reset, error_warning_reset, restart_counter_reset}), 8'h7);
    i_smrc_host.put(3'h7, 4'h0, 1'h0, 4'h1, 1'h1);
    wt(8);
    chk("limp act", 8'({mode, channel_drive}), 8'({SMRC_LIMP_ACT, 4'h1}));
    chk("limp prot", 8'({protection_enable, sense_available}), 8'h2);
    i_smrc_host.put(3'h0, 4'h0, 1'h0, 4'h0, 1'h0);
    wt(8);
    i_smrc_host.read(dw);
    // limp input at battery transient level
    supply_in = 4'h8;
    i_smrc_host.put(3'h0, 4'h0, 1'h0, 4'h0, 1'h1);
    wt(ACK + 8);
    chk("tp mode", 8'(mode), 8'(SMRC_STANDBY));
    chk("tp flags", 8'(standard_diag_word), 8'h7);
    supply_in = 4'hf;
    i_smrc_host.put(3'h0, 4'h1, 1'h0, 4'h0, 1'h0);
    wt(UV + 10);
    i_smrc_host.read(dw);
    chk("act drive", 8'(channel_drive), 8'h1);
    // battery undervoltage and delayed restart
    supply_in = 4'hc;
    wt(6);
    chk("uv drive", 8'(channel_drive), 8'h0);
    supply_in = 4'hf;
    wt(UV - 8);
    chk("uv hold", 8'(channel_drive), 8'h0);
    chk("uv flag", 8'(standard_diag_word.supply_monitor_flag), 8'h1);
    wt(16);
    chk("uv restart", 8'(channel_drive), 8'h1);
    // configuration reset command
    i_smrc_host.cmd(1'h1);
    wt(3);
    chk("cfg cmd", 8'({config_reset, error_warning_reset, restart_counter_reset, diag_word_reset}), 8'h8);
    i_smrc_host.cmd(1'h0);
    // logic supply loss with pins low
    supply_in = 4'h7;
    wt(8);
    chk("vdd mode", 8'({mode, config_reset}), 8'({SMRC_SLEEP, 1'b1}));
    supply_in = 4'hf;
    wt(8);
    chk("vdd ter", 8'(standard_diag_word.transmission_error_flag), 8'h1);
    print_verdict();
  end
endmodule : smrc_ctrl_tb
